// ===== common/ldp_params.svh
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH
// What this block does
// [RULE1] A 4-bit rate code picks one of sixteen PWM rates, 200 Hz to 20.8 kHz.
// [RULE2] Pulses down to one microsecond are possible on all twelve channels.
// [RULE3] A period is 256 base steps; on time is the upper eight code bits.
// [RULE4] The low four code bits dither on time over periods for 12-bit resolution.
// [RULE5] Internal base steps come from the system clock at 256 times the rate.
// [RULE6] Linear mode takes high byte and low nibble straight into the code.
// [RULE7] Linear duty equals (16 times high byte plus nibble plus 1) over 4096.
// [RULE8] A nibble of Fh switches dithering off for that channel.
// [RULE9] Nibble writes wait; the duty changes only when the high byte is written.
// [RULE10] With common duty enabled every channel uses the duty of channel 0. In fail-safe each channel still takes its own stored byte.
// [RULE11] Exponential mode maps the high byte through a table; nibble ignored.
// [RULE12] Power-up and fail-safe reload curve, high bytes, rate; nibbles become Fh.
// [RULE13] Fail-safe duty is the stored byte only, (value plus 1) over 256.
// [RULE14] External timebase only with address option set and source select set.
// [RULE15] The external clock runs at 256 times the rate, for PWM only.
// [RULE16] The external clock should stay below 1 MHz.
// [RULE17] With address option set, group inputs gate outputs 0-5 and 6-11, active low.
// [RULE18] Host should program FFh and Fh when external dimming inputs are used.
// [RULE19] Host should choose rates above 2 kHz with dithering or exponential curve.
// [RULE20] A channel drives only while its enable bit is one.
// [RULE21] Output is on only in PWM on phase, enabled, and group input low or address option clear.
// [RULE22] Periods start in the on phase; new codes apply at period boundaries.
`define LDP_CLK_HZ 100000000
`define LDP_STEPS 256
`define LDP_NO_DITHER 4'hf
`define LDP_RATE_HZ_0 200
`define LDP_RATE_HZ_1 300
`define LDP_RATE_HZ_2 400
`define LDP_RATE_HZ_3 500
`define LDP_RATE_HZ_4 600
`define LDP_RATE_HZ_5 700
`define LDP_RATE_HZ_6 800
`define LDP_RATE_HZ_7 1000
`define LDP_RATE_HZ_8 1200
`define LDP_RATE_HZ_9 1600
`define LDP_RATE_HZ_10 2000
`define LDP_RATE_HZ_11 3000
`define LDP_RATE_HZ_12 5000
`define LDP_RATE_HZ_13 8000
`define LDP_RATE_HZ_14 13000
`define LDP_RATE_HZ_15 20800
`define LDP_OFS_CTRL 12'h000
`define LDP_OFS_ENABLE 12'h004
`define LDP_OFS_STATUS 12'h008
`define LDP_OFS_HI_BASE 12'h040
`define LDP_OFS_LO_BASE 12'h080
`define LDP_CTRL_CURVE 0
`define LDP_CTRL_COMMON 1
`define LDP_CTRL_SOURCE 2
`define LDP_CTRL_RATE_LSB 4
`define LDP_ST_FAILSAFE 16
`define LDP_ST_EXT_TB 17
`endif

// ===== common/ldp_pkg.sv
package ldp_pkg;
    typedef logic [11:0] ldp_code_t;
    typedef logic [7:0] ldp_byte_t;
    typedef logic [3:0] ldp_nib_t;
endpackage : ldp_pkg

// ===== common/ldp_link_if.sv
// Timebase control and exponential table access between core and helpers
interface ldp_link_if;
    logic [3:0] rate_sel;
    logic use_ext;
    logic base_tick;
    ldp_pkg::ldp_byte_t lut_addr;
    ldp_pkg::ldp_code_t lut_data;
    modport core (output rate_sel, output use_ext, input base_tick,
                  output lut_addr, input lut_data);
    modport timebase (input rate_sel, input use_ext, output base_tick);
    modport rom (input lut_addr, output lut_data);
endinterface : ldp_link_if

// ===== hdl/ldp_timebase.sv
`include "ldp_params.svh"
module ldp_timebase #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // External timebase pin, asynchronous
    input wire logic ext_pin,
    // Rate select and base tick
    ldp_link_if.timebase lnk
);
    // Slowest rate must fit the divider
    if ((`LDP_CLK_HZ / (`LDP_STEPS * `LDP_RATE_HZ_0)) >= (1 << DIV_W)) begin : g_bad_div
        $error("ldp_timebase: DIV_W too small for the slowest rate");
    end

    // Clock cycles per base step; rounds down so the rate never runs slow
    function automatic logic [DIV_W-1:0] step_cycles(input logic [3:0] code);
        int hz;
        case (code)
            4'h0: hz = `LDP_RATE_HZ_0;
            4'h1: hz = `LDP_RATE_HZ_1;
            4'h2: hz = `LDP_RATE_HZ_2;
            4'h3: hz = `LDP_RATE_HZ_3;
            4'h4: hz = `LDP_RATE_HZ_4;
            4'h5: hz = `LDP_RATE_HZ_5;
            4'h6: hz = `LDP_RATE_HZ_6;
            4'h7: hz = `LDP_RATE_HZ_7;
            4'h8: hz = `LDP_RATE_HZ_8;
            4'h9: hz = `LDP_RATE_HZ_9;
            4'ha: hz = `LDP_RATE_HZ_10;
            4'hb: hz = `LDP_RATE_HZ_11;
            4'hc: hz = `LDP_RATE_HZ_12;
            4'hd: hz = `LDP_RATE_HZ_13;
            4'he: hz = `LDP_RATE_HZ_14;
            default: hz = `LDP_RATE_HZ_15;
        endcase
        step_cycles = DIV_W'(`LDP_CLK_HZ / (`LDP_STEPS * hz));
    endfunction : step_cycles

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] last_w;
    logic [2:0] ext_q;
    logic tick_q;
    logic int_end;
    logic ext_rise;

    assign last_w = step_cycles(lnk.rate_sel) - DIV_W'(1);
    assign int_end = (div_q >= last_w);
    assign ext_rise = ext_q[1] & ~ext_q[2];

    // Pin synchroniser plus one stage for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 3'h0;
        end else begin
            ext_q <= {ext_q[1:0], ext_pin};
        end
    end

    // Internal divider; >= compare recovers at once from a rate change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (lnk.use_ext || int_end) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1); // see [RULE5]
        end
    end

    // One tick per base step, from either source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= lnk.use_ext ? ext_rise : int_end; // see [RULE1] see [RULE15]
        end
    end

    assign lnk.base_tick = tick_q;

    chk_tick_phase: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE5]
        tick_q && !$past(lnk.use_ext) |-> div_q == '0)
        else $error("internal tick not aligned with divider restart");
    chk_ext_gated: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE14]
        $past(lnk.use_ext) && !$past(ext_rise) |-> !tick_q)
        else $error("external tick without a pin edge");
endmodule : ldp_timebase

// ===== hdl/ldp_exp_rom.sv
module ldp_exp_rom (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Table port
    ldp_link_if.rom lnk
);
    // Strictly rising curve: linear for 0..31, then mantissa doubled per octave
    function automatic ldp_pkg::ldp_code_t exp_code(input ldp_pkg::ldp_byte_t x);
        logic [5:0] mant;
        mant = {1'b1, x[4:0]};
        if (x[7:5] == 3'h0) begin
            exp_code = {7'h00, x[4:0]};
        end else begin
            exp_code = 12'(mant) << (x[7:5] - 3'h1);
        end
    endfunction : exp_code

    ldp_pkg::ldp_code_t data_q;

    // Registered read, one cycle latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 12'h000;
        end else begin
            data_q <= exp_code(lnk.lut_addr); // see [RULE11]
        end
    end

    assign lnk.lut_data = data_q;
endmodule : ldp_exp_rom

// ===== hdl/ldp_dimming_core.sv
`include "ldp_params.svh"
module ldp_dimming_core #(
    parameter int CHANNELS = 12,
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stored defaults, static
    input wire logic stored_curve_select,
    input wire logic [CHANNELS*8-1:0] stored_duty_high,
    input wire logic [3:0] stored_dim_rate,
    input wire logic stored_address_option,
    // Fail-safe level from the supervisor, same clock
    input wire logic failsafe_req,
    // Pins, asynchronous
    input wire logic addr2_or_ext_timebase_pin,
    input wire logic group_a_dim_input_n,
    input wire logic group_b_dim_input_n,
    // Channel current switches
    output logic [CHANNELS-1:0] current_output
);
    // Register banks hold 16 words; groups split evenly
    if (CHANNELS < 2 || CHANNELS > 16 || (CHANNELS % 2) != 0) begin : g_bad_ch
        $error("ldp_dimming_core: CHANNELS must be even, 2 to 16");
    end

    localparam int HALF = CHANNELS / 2;

    // Word belongs to a per-channel bank
    function automatic logic hit_bank(input logic [11:0] a, input logic [11:0] base);
        hit_bank = (a[11:6] == base[11:6]) && ({1'b0, a[5:2]} < 5'(CHANNELS)) &&
                   (a[1:0] == 2'h0);
    endfunction : hit_bank

    // Address answers on the bus
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `LDP_OFS_CTRL) || (a == `LDP_OFS_ENABLE) ||
                 (a == `LDP_OFS_STATUS) || hit_bank(a, `LDP_OFS_HI_BASE) ||
                 hit_bank(a, `LDP_OFS_LO_BASE);
    endfunction : mapped

    // On phase: high byte steps, plus one when this frame falls in the dither share
    function automatic logic pwm_on(input logic [7:0] step, input logic [3:0] frame,
                                    input ldp_pkg::ldp_code_t code);
        logic [8:0] on_len;
        on_len = {1'b0, code[11:4]} + {8'h00, (frame <= code[3:0])};
        pwm_on = {1'b0, step} < on_len;
    endfunction : pwm_on

    ldp_link_if lnk ();

    logic curve_q;
    logic common_q;
    logic source_q;
    logic [3:0] rate_q;
    logic [CHANNELS-1:0] enable_q;
    ldp_pkg::ldp_nib_t lo_pend_q [CHANNELS];
    ldp_pkg::ldp_code_t act_q [CHANNELS];
    ldp_pkg::ldp_code_t next_q [CHANNELS];
    ldp_pkg::ldp_code_t run_q [CHANNELS];
    ldp_pkg::ldp_code_t lin_q;
    ldp_pkg::ldp_code_t safe_q;
    ldp_pkg::ldp_code_t res_code;
    logic load_q;
    logic fs_q;
    logic reload;
    logic [7:0] step_q;
    logic [3:0] frame_q;
    logic boundary;
    logic [3:0] scan_q;
    logic [3:0] scan_d1_q;
    logic [3:0] src_ch;
    logic [1:0] grp_a_q;
    logic [1:0] grp_b_q;
    logic [CHANNELS-1:0] out_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_word;
    logic acc;
    logic wr_en;

    ldp_timebase #(
        .DIV_W(DIV_W)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .ext_pin(addr2_or_ext_timebase_pin),
        .lnk(lnk.timebase)
    );

    ldp_exp_rom u_exp_rom (
        .pclk(pclk),
        .presetn(presetn),
        .lnk(lnk.rom)
    );

    // Bus handshake: every access takes one wait state so data come from flops
    assign acc = psel && penable;
    assign wr_en = acc && pwrite && pready_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !mapped(paddr);
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == `LDP_OFS_CTRL) begin
            rd_word[`LDP_CTRL_CURVE] = curve_q;
            rd_word[`LDP_CTRL_COMMON] = common_q;
            rd_word[`LDP_CTRL_SOURCE] = source_q;
            rd_word[`LDP_CTRL_RATE_LSB +: 4] = rate_q;
        end else if (paddr == `LDP_OFS_ENABLE) begin
            rd_word[CHANNELS-1:0] = enable_q;
        end else if (paddr == `LDP_OFS_STATUS) begin
            rd_word[CHANNELS-1:0] = out_q;
            rd_word[`LDP_ST_FAILSAFE] = fs_q;
            rd_word[`LDP_ST_EXT_TB] = lnk.use_ext;
        end else if (hit_bank(paddr, `LDP_OFS_HI_BASE)) begin
            rd_word[7:0] = act_q[paddr[5:2]][11:4];
        end else if (hit_bank(paddr, `LDP_OFS_LO_BASE)) begin
            rd_word[3:0] = lo_pend_q[paddr[5:2]];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc && !pready_q && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    // Defaults load one cycle after reset release and on entering fail-safe
    assign reload = load_q || (failsafe_req && !fs_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b1;
            fs_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            fs_q <= failsafe_req;
        end
    end

    // Control word; common and source keep their value through fail-safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            curve_q <= 1'b0;
            common_q <= 1'b0;
            source_q <= 1'b0;
            rate_q <= 4'h0;
        end else if (reload) begin
            curve_q <= stored_curve_select; // see [RULE12]
            rate_q <= stored_dim_rate;
        end else if (wr_en && paddr == `LDP_OFS_CTRL) begin
            curve_q <= pwdata[`LDP_CTRL_CURVE];
            common_q <= pwdata[`LDP_CTRL_COMMON];
            source_q <= pwdata[`LDP_CTRL_SOURCE];
            rate_q <= pwdata[`LDP_CTRL_RATE_LSB +: 4]; // see [RULE1]
        end
    end

    // Channel enables, off after reset to avoid a flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= '0;
        end else if (wr_en && paddr == `LDP_OFS_ENABLE) begin
            enable_q <= pwdata[CHANNELS-1:0];
        end
    end

    assign lnk.rate_sel = rate_q;
    assign lnk.use_ext = stored_address_option && source_q; // see [RULE14]

    // Period counter and dither frame
    assign boundary = lnk.base_tick && (step_q == 8'hff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 8'h00;
            frame_q <= 4'h0;
        end else if (lnk.base_tick) begin
            step_q <= step_q + 8'h01; // see [RULE3]
            if (boundary) begin
                frame_q <= frame_q + 4'h1; // see [RULE4]
            end
        end
    end

    // Scanner resolves one channel code per cycle through the table
    assign src_ch = common_q ? 4'h0 : scan_q; // see [RULE10]
    assign lnk.lut_addr = act_q[src_ch][11:4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_q <= 4'h0;
            scan_d1_q <= 4'h0;
            lin_q <= 12'h000;
            safe_q <= 12'h000;
        end else begin
            scan_q <= (scan_q == 4'(CHANNELS - 1)) ? 4'h0 : scan_q + 4'h1;
            scan_d1_q <= scan_q;
            lin_q <= act_q[src_ch]; // see [RULE6]
            safe_q <= {stored_duty_high[scan_q*8 +: 8], `LDP_NO_DITHER}; // see [RULE13]
        end
    end

    // Fail-safe wins, then curve choice
    always_comb begin
        if (fs_q) begin
            res_code = safe_q;
        end else if (curve_q) begin
            res_code = lnk.lut_data; // see [RULE11]
        end else begin
            res_code = lin_q; // see [RULE7]
        end
    end

    // Group input synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_a_q <= 2'h0;
            grp_b_q <= 2'h0;
        end else begin
            grp_a_q <= {grp_a_q[0], group_a_dim_input_n};
            grp_b_q <= {grp_b_q[0], group_b_dim_input_n};
        end
    end

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic grp_off;
        assign grp_off = stored_address_option && // see [RULE17]
                         ((c < HALF) ? grp_a_q[1] : grp_b_q[1]);

        // Nibble waits; high byte write commits both halves at once
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lo_pend_q[c] <= `LDP_NO_DITHER;
                act_q[c] <= 12'h000;
            end else if (reload) begin
                lo_pend_q[c] <= `LDP_NO_DITHER; // see [RULE12]
                act_q[c] <= {stored_duty_high[c*8 +: 8], `LDP_NO_DITHER};
            end else if (wr_en && paddr[5:2] == 4'(c)) begin
                if (hit_bank(paddr, `LDP_OFS_LO_BASE)) begin
                    lo_pend_q[c] <= pwdata[3:0];
                end
                if (hit_bank(paddr, `LDP_OFS_HI_BASE)) begin
                    act_q[c] <= {pwdata[7:0], lo_pend_q[c]}; // see [RULE9]
                end
            end
        end

        // Resolved code waits for the period boundary
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                next_q[c] <= 12'h000;
                run_q[c] <= 12'h000;
            end else begin
                if (scan_d1_q == 4'(c)) begin
                    next_q[c] <= res_code;
                end
                if (boundary) begin
                    run_q[c] <= next_q[c]; // see [RULE22]
                end
            end
        end

        // Switch: on phase, enabled and not held off by the group pin
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_q[c] <= 1'b0;
            end else begin
                out_q[c] <= pwm_on(step_q, frame_q, run_q[c]) && // see [RULE21] see [RULE8]
                            enable_q[c] && !grp_off; // see [RULE20] see [RULE2]
            end
        end
    end

    assign current_output = out_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    chk_step_advance: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
        lnk.base_tick |=> step_q == $past(step_q) + 8'h01)
        else $error("period counter did not advance on tick");
    chk_enable_off: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE20]
        !enable_q[0] |=> !current_output[0])
        else $error("disabled channel drove its output");
    chk_group_gate: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE17]
        stored_address_option && grp_a_q[1] |=> current_output[0] == 1'b0)
        else $error("group input high did not hold channel off");
    chk_no_dither: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE8]
        run_q[0][3:0] == 4'hf |-> pwm_on(step_q, frame_q, run_q[0]) ==
            ({1'b0, step_q} <= {1'b0, run_q[0][11:4]}))
        else $error("dither active with nibble Fh");
    chk_low_write_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9]
        wr_en && paddr == `LDP_OFS_LO_BASE && !reload |=> act_q[0] == $past(act_q[0]))
        else $error("nibble write changed active duty");
    chk_high_apply: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9]
        wr_en && paddr == `LDP_OFS_HI_BASE && !reload |=>
            act_q[0] == {$past(pwdata[7:0]), $past(lo_pend_q[0])})
        else $error("high byte write did not commit duty");
    chk_period_latch: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE22]
        boundary |=> run_q[1] == $past(next_q[1]) ##1 $stable(run_q[1]))
        else $error("code not latched at period boundary");
    chk_failsafe_load: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE12]
        failsafe_req && !fs_q |=> rate_q == $past(stored_dim_rate) && lo_pend_q[0] == 4'hf)
        else $error("fail-safe did not reload defaults");
endmodule : ldp_dimming_core

// ===== sim/ldp_ext_source.sv
// Far side: free-running external timebase for the dimming counters
module ldp_ext_source #(
    parameter int HALF_NS = 20
) (
    // Run control
    input wire logic run,
    // External timebase pin
    output logic tb_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Far above the advised 1 MHz ceiling, a known limitation: a slower pin
    // would not fit 16 full periods in a short run
    // Each level still spans two system clocks for the synchroniser
    initial begin
        tb_pin = 1'b0;
        #3;
        forever begin
            #(HALF_NS) tb_pin = run ? ~tb_pin : 1'b0;
        end
    end
endmodule : ldp_ext_source

// ===== sim/led_channel_dimming_pwm_tb_top.sv
`include "ldp_params.svh"
module led_channel_dimming_pwm_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic curve_s = 1'b0;
    logic [95:0] duty_s = 96'h0;
    logic [3:0] rate_s = 4'h0;
    logic failsafe = 1'b0;
    logic grp_b_n = 1'b1;
    logic grp_a_n = 1'b0; // Grounded while unused
    logic [5:0] seen_a = 6'h0;
    logic ext_pin;
    logic [11:0] current_output;
    logic [31:0] rnd = 32'h4ac0c457;
    logic [32:0] exq[$];
    int cnt[12];
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    // Clock, 100 MHz
    always #5 pclk = ~pclk;

    ldp_dimming_core uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stored_curve_select(curve_s),
        .stored_duty_high(duty_s), .stored_dim_rate(rate_s),
        .stored_address_option(1'b1), .failsafe_req(failsafe),
        .addr2_or_ext_timebase_pin(ext_pin), .group_a_dim_input_n(grp_a_n),
        .group_b_dim_input_n(grp_b_n), .current_output(current_output)
    );

    ldp_ext_source #(.HALF_NS(20)) src (.run(1'b1), .tb_pin(ext_pin));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // Expected answer is queued first, then the request is held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Any 4096 consecutive ticks span one full dither cycle of 16 periods
    task automatic count_on;
        repeat (512) @(posedge ext_pin);
        cnt = '{default: 0};
        repeat (4096) begin
            @(posedge ext_pin);
            for (int c = 0; c < 12; c++) cnt[c] += int'(current_output[c]);
        end
        // Back onto a clock edge so later input changes land there
        @(posedge pclk);
    endtask : count_on

    // Watch completed transfers and compare against the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (pwrite)
                check({pslverr, 32'h0}, {exq[0][32], 32'h0});
            else
                check({pslverr, prdata}, exq[0]);
            void'(exq.pop_front());
        end
    end

    // Hang guard, a little above the four measurements
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            duty_s[i*32 +: 32] = rnd;
        end
        rate_s = rnd[3:0];
        curve_s = rnd[4];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `LDP_OFS_CTRL, 32'h0, {25'h0, rate_s, 3'h0, curve_s});
        apb(1'b0, `LDP_OFS_HI_BASE + 12'h014, 32'h0, {25'h0, duty_s[47:40]});
        apb(1'b0, `LDP_OFS_LO_BASE + 12'h014, 32'h0, 33'hf);
        apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h0fc, 32'h5, {1'b1, 32'h0});
        // Linear mode on the external timebase (pin sets the rate, 3 kHz code ignored), channel 3 left disabled
        apb(1'b1, `LDP_OFS_CTRL, 32'hb4, 33'h0);
        apb(1'b1, `LDP_OFS_ENABLE, 32'hff7, 33'h0);
        apb(1'b1, `LDP_OFS_LO_BASE + 12'h014, 32'h2, 33'h0);
        apb(1'b1, `LDP_OFS_LO_BASE, 32'h3, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE, 32'h80, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE + 12'h004, 32'h10, 33'h0);
        apb(1'b1, `LDP_OFS_LO_BASE + 12'h008, 32'h0, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE + 12'h008, 32'h0, 33'h0);
        count_on();
        check(33'(cnt[0]), 33'd2052);
        check(33'(cnt[1]), 33'd272);
        check(33'(cnt[2]), 33'd1);
        check(33'(cnt[3]), 33'd0);
        check(33'(cnt[5]), 33'((duty_s[47:40] + 9'h1) * 16));
        check(33'(cnt[6]), 33'd0);
        // Exponential curve
        apb(1'b1, `LDP_OFS_CTRL, 32'hb5, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE, 32'h40, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE + 12'h004, 32'h10, 33'h0);
        count_on();
        check(33'(cnt[0]), 33'd65);
        check(33'(cnt[1]), 33'd17);
        // Common duty, group B released to on
        grp_b_n <= 1'b0;
        apb(1'b1, `LDP_OFS_CTRL, 32'hb6, 33'h0);
        apb(1'b1, `LDP_OFS_HI_BASE, 32'h20, 33'h0);
        count_on();
        check(33'(cnt[1]), 33'd516);
        check(33'(cnt[6]), 33'd516);
        check(33'(cnt[11]), 33'd516);
        // Fail-safe: stored bytes only
        failsafe <= 1'b1;
        count_on();
        for (int c = 0; c < 12; c++)
            check(33'(cnt[c]),
                  c == 3 ? 33'h0 : 33'((duty_s[8*c +: 8] + 9'h1) * 16));
        // Group A pin high must hold outputs 0-5 dark over a whole period;
        // every enabled channel has at least one on step per period here
        grp_a_n <= 1'b1;
        repeat (4) @(posedge pclk);
        repeat (1100) begin
            @(negedge pclk);
            seen_a = seen_a | current_output[5:0];
        end
        check(33'(seen_a), 33'h0);
        end_of_test();
    end
endmodule : led_channel_dimming_pwm_tb_top
